// ---- design/dhfc_pkg.sv ----
// Constants, coefficient tables, carriers and helpers of the filter chain
// How it works
// - Half-band halves the rate on I and Q
// - Symmetric 19-tap polyphase half-band, nonzero taps only
// - Odd half-band taps beside centre are zero
// - Fixed 20-bit half-band coefficient set
// - Half-band stage is never bypassed
// - Half-band control bit 1 selects high-pass
// - Half-band control bit 2 reverses the spectrum
// - Half-band control bit 3 selects decimation phase
// - 66-tap 21-bit sum-of-products FIR follows
// - FIR gives one output per input
// - FIR control bit 0 enables FIR
// - Fixed symmetric 21-bit FIR coefficient set
// - Sync bits choose every or first sync
// - Accepted sync restarts at programmed phase
// - I and Q filtered identically in parallel
// - Final shifter moves to rate/8, real out
// - Shifter bypassed interleaves I and Q
package dhfc_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int REG_ADDR_W = 9;
   localparam int REG_DATA_W = 8;
   localparam logic [REG_ADDR_W-1:0] ADDR_SYNC_CTRL = 9'h100;
   localparam logic [REG_ADDR_W-1:0] ADDR_FIR_CTRL = 9'h102;
   localparam logic [REG_ADDR_W-1:0] ADDR_HB_CTRL = 9'h103;
   localparam logic [REG_DATA_W-1:0] REG_RESET = 8'h00;
   localparam logic [REG_DATA_W-1:0] REG_UNMAPPED = 8'h00;
   localparam int BIT_SYNC_EN = 5;
   localparam int BIT_SYNC_ONCE = 6;
   localparam int BIT_SYNC_ARMED = 7;
   localparam int BIT_FIR_EN = 0;
   localparam int BIT_SHIFT_EN = 1;
   localparam int BIT_OVF = 7;
   localparam int BIT_HIGHPASS = 1;
   localparam int BIT_REVERSE = 2;
   localparam int BIT_DEC_PHASE = 3;

   // ************************************************************
   // Datapath sizes
   // ************************************************************
   localparam int DATA_W = 16;
   localparam int ACC_W = 48;
   localparam int NUM_LANE = 4;
   localparam int HB_TAPS = 19;
   localparam int HB_CENTRE = 9;
   localparam int HB_PAIRS = 5;
   localparam int HB_SHIFT = 20;
   localparam int FIR_TAPS = 66;
   localparam int FIR_PAIRS = 33;
   localparam int FIR_SHIFT = 21;
   localparam int SHIFT_PH_W = 2;
   localparam int FIFO_DEPTH_DEF = 32;

   // ************************************************************
   // Coefficients, outer pair first
   // ************************************************************
   localparam logic signed [19:0] HB_CENTRE_COEF = 20'sd524287;
   localparam logic signed [19:0] HB_COEF [HB_PAIRS] = '{
      20'sd844, -20'sd6189, 20'sd25080, -20'sd79170, 20'sd321584};
   localparam logic signed [20:0] FIR_COEF [FIR_PAIRS] = '{
      21'sd383, 21'sd1431, 21'sd1950, 21'sd96, -21'sd2661, -21'sd1750,
      21'sd2476, 21'sd2388, -21'sd3867, -21'sd5150, 21'sd3788, 21'sd7513,
      -21'sd4511, -21'sd11914, 21'sd3650, 21'sd16484, -21'sd2818,
      -21'sd23200, -21'sd48, 21'sd30748, 21'sd3976, -21'sd41019,
      -21'sd11147, 21'sd53608, 21'sd21818, -21'sd71611, -21'sd40300,
      21'sd98830, 21'sd74264, -21'sd152696, -21'sd161248, 21'sd337056,
      21'sd922060};

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic signed [DATA_W-1:0] i;
      logic signed [DATA_W-1:0] q;
   } dhfc_iq_t;

   typedef struct packed {
      logic q_tag;
      logic signed [DATA_W-1:0] ch1;
      logic signed [DATA_W-1:0] ch0;
   } dhfc_word_t;

   localparam int WORD_W = $bits(dhfc_word_t);

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic signed [DATA_W-1:0] dhfc_sat(
      input logic signed [ACC_W-1:0] v);
      logic signed [DATA_W-1:0] r;
      r = v[DATA_W-1:0];
      if (v[ACC_W-1:DATA_W-1] != '0 && v[ACC_W-1:DATA_W-1] != '1) begin
         r = v[ACC_W-1] ? {1'b1, {(DATA_W-1){1'b0}}} :
            {1'b0, {(DATA_W-1){1'b1}}};
      end
      return r;
   endfunction : dhfc_sat

   // Saturating negate: full-scale negative would wrap otherwise
   function automatic logic signed [DATA_W-1:0] dhfc_neg(
      input logic signed [DATA_W-1:0] x);
      return dhfc_sat(-(ACC_W'(x)));
   endfunction : dhfc_neg

endpackage : dhfc_pkg

// ---- design/dhfc_fifo.sv ----
// Output FIFO with a registered read port
`timescale 1ns/10ps
module dhfc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Filling side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic out_valid_r;
   logic [W-1:0] out_data_r;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == LAST_PTR) ? '0 : p + 1'b1;
   endfunction : bump

   wire push = in_valid && in_ready;
   wire pop = (count_r != '0) && (!out_valid_r || out_ready);
   assign in_ready = (count_r != FULL_CNT);
   assign out_valid = out_valid_r;
   assign out_data = out_data_r;

   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr_r] <= in_data;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         out_valid_r <= 1'b0;
         out_data_r <= '0;
      end else begin
         if (push) wr_ptr_r <= bump(wr_ptr_r);
         if (pop) rd_ptr_r <= bump(rd_ptr_r);
         if (push && !pop) count_r <= count_r + 1'b1;
         else if (pop && !push) count_r <= count_r - 1'b1;
         if (pop) out_data_r <= mem[rd_ptr_r];
         if (pop) out_valid_r <= 1'b1;
         else if (out_ready) out_valid_r <= 1'b0;
      end
   end
endmodule : dhfc_fifo

// ---- design/dhfc_chain.sv ----
// Decimating half-band and FIR chain for two converter channels
`timescale 1ns/10ps
module dhfc_chain
   import dhfc_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Tuned complex samples, one per clock per channel
   input wire dhfc_iq_t IN_CH0,
   input wire dhfc_iq_t IN_CH1,
   // External sync pin
   input wire logic SYNC_IN,
   // Register port
   input wire logic REG_WE,
   input wire logic REG_RE,
   input wire logic [REG_ADDR_W-1:0] REG_ADDR,
   input wire logic [REG_DATA_W-1:0] REG_WDATA,
   output logic [REG_DATA_W-1:0] REG_RDATA,
   output logic REG_RVALID,
   // Output stream to the formatter
   output dhfc_word_t OUT_WORD,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic OVERFLOW
);

   // ************************************************************
   // Registers
   // ************************************************************
   logic [REG_DATA_W-1:0] sync_ctrl_r;
   logic [REG_DATA_W-1:0] fir_ctrl_r;
   logic [REG_DATA_W-1:0] hb_ctrl_r;
   logic [REG_DATA_W-1:0] rdata_r;
   logic rvalid_r;
   logic armed_r;
   logic armed_nxt;
   logic ovf_r;
   logic ovf_nxt;
   logic [REG_DATA_W-1:0] sync_rd;
   logic [REG_DATA_W-1:0] fir_rd;
   logic fifo_in_ready;

   wire hit_sync = (REG_ADDR == ADDR_SYNC_CTRL);
   wire hit_fir = (REG_ADDR == ADDR_FIR_CTRL);
   wire hit_hb = (REG_ADDR == ADDR_HB_CTRL);
   wire wr_sync = REG_WE && hit_sync;
   wire wr_fir = REG_WE && hit_fir;
   wire wr_hb = REG_WE && hit_hb;

   // One register set feeds all four lanes of both channels
   wire sync_en = sync_ctrl_r[BIT_SYNC_EN];
   wire sync_once = sync_ctrl_r[BIT_SYNC_ONCE];
   wire fir_en = fir_ctrl_r[BIT_FIR_EN];
   wire shift_en = fir_ctrl_r[BIT_SHIFT_EN];
   wire highpass = hb_ctrl_r[BIT_HIGHPASS];
   wire reverse = hb_ctrl_r[BIT_REVERSE];
   wire dec_phase = hb_ctrl_r[BIT_DEC_PHASE];

   always_comb begin
      sync_rd = sync_ctrl_r;
      sync_rd[BIT_SYNC_ARMED] = armed_r;
      fir_rd = fir_ctrl_r;
      fir_rd[BIT_OVF] = ovf_r;
   end

   wire [REG_DATA_W-1:0] rd_mux = hit_sync ? sync_rd :
      hit_fir ? fir_rd :
      hit_hb ? hb_ctrl_r : REG_UNMAPPED;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sync_ctrl_r <= REG_RESET;
         fir_ctrl_r <= REG_RESET;
         hb_ctrl_r <= REG_RESET;
         rdata_r <= REG_RESET;
         rvalid_r <= 1'b0;
      end else begin
         if (wr_sync) sync_ctrl_r <= REG_WDATA;
         if (wr_fir) fir_ctrl_r <= REG_WDATA;
         if (wr_hb) hb_ctrl_r <= REG_WDATA;
         if (REG_RE) rdata_r <= rd_mux;
         rvalid_r <= REG_RE;
      end
   end

   assign REG_RDATA = rdata_r;
   assign REG_RVALID = rvalid_r;

   // ************************************************************
   // Sync alignment
   // ************************************************************
   logic sync_s1_r;
   logic sync_s2_r;
   logic sync_s3_r;
   logic dec_cnt_r;
   logic hb_v_r;
   logic fir_v_r;

   wire sync_edge = sync_s2_r && !sync_s3_r;
   // First-pulse mode needs a write to re-arm
   wire sync_accept = sync_edge && sync_en && (!sync_once || armed_r);
   // A write in the accept cycle re-arms, so that write is not lost
   assign armed_nxt = wr_sync ? 1'b1 : (sync_accept ? 1'b0 : armed_r);
   // Half-band runs every other clock; an accepted sync reloads dec_phase and can skip or repeat a slot
   wire hb_fire = !dec_cnt_r;
   wire dec_cnt_nxt = sync_accept ? dec_phase : !dec_cnt_r;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sync_s1_r <= 1'b0;
         sync_s2_r <= 1'b0;
         sync_s3_r <= 1'b0;
         armed_r <= 1'b0;
         dec_cnt_r <= 1'b0;
         hb_v_r <= 1'b0;
         fir_v_r <= 1'b0;
      end else begin
         sync_s1_r <= SYNC_IN;
         sync_s2_r <= sync_s1_r;
         sync_s3_r <= sync_s2_r;
         armed_r <= armed_nxt;
         dec_cnt_r <= dec_cnt_nxt;
         hb_v_r <= hb_fire;
         fir_v_r <= hb_v_r;
      end
   end

   // ************************************************************
   // Filter lanes: ch0 I, ch0 Q, ch1 I, ch1 Q
   // ************************************************************
   logic signed [DATA_W-1:0] lane_in [NUM_LANE];
   logic signed [DATA_W-1:0] hb_out [NUM_LANE];
   logic signed [DATA_W-1:0] fir_out [NUM_LANE];
   logic signed [DATA_W-1:0] st [NUM_LANE];

   assign lane_in[0] = IN_CH0.i;
   assign lane_in[1] = IN_CH0.q;
   assign lane_in[2] = IN_CH1.i;
   assign lane_in[3] = IN_CH1.q;

   for (genvar l = 0; l < NUM_LANE; l++) begin : g_lane
      localparam bit IS_Q = (l % 2) == 1;
      logic signed [DATA_W-1:0] hb_dl [HB_TAPS-1];
      logic signed [DATA_W-1:0] hb_win [HB_TAPS];
      logic signed [DATA_W-1:0] fir_dl [FIR_TAPS-1];
      logic signed [DATA_W-1:0] fir_win [FIR_TAPS];
      logic signed [ACC_W-1:0] hb_acc;
      logic signed [ACC_W-1:0] fir_acc;
      logic signed [DATA_W-1:0] hb_y;

      always_comb begin
         hb_win[0] = lane_in[l];
         for (int k = 1; k < HB_TAPS; k++) begin
            hb_win[k] = hb_dl[k-1];
         end
         fir_win[0] = hb_out[l];
         for (int k = 1; k < FIR_TAPS; k++) begin
            fir_win[k] = fir_dl[k-1];
         end
      end

      // Polyphase: only the even taps and the centre are multiplied
      always_comb begin : hb_mac
         logic signed [ACC_W-1:0] side;
         side = '0;
         for (int p = 0; p < HB_PAIRS; p++) begin
            side = side + ACC_W'(HB_COEF[p]) *
               (ACC_W'(hb_win[2*p]) + ACC_W'(hb_win[HB_TAPS-1-2*p]));
         end
         // Mirroring to high-pass flips every tap but the centre
         hb_acc = ACC_W'(HB_CENTRE_COEF) * ACC_W'(hb_win[HB_CENTRE]) +
            (highpass ? -side : side);
      end

      // Full 66-tap product sum, folded on the symmetric pairs
      always_comb begin : fir_mac
         fir_acc = '0;
         for (int p = 0; p < FIR_PAIRS; p++) begin
            fir_acc = fir_acc + ACC_W'(FIR_COEF[p]) *
               (ACC_W'(fir_win[p]) + ACC_W'(fir_win[FIR_TAPS-1-p]));
         end
      end

      assign hb_y = dhfc_sat(hb_acc >>> HB_SHIFT);
      assign st[l] = fir_en ? fir_out[l] : hb_out[l];

      always_ff @(posedge CLOCK) begin
         if (RST) begin
            for (int k = 0; k < HB_TAPS-1; k++) begin
               hb_dl[k] <= '0;
            end
            hb_out[l] <= '0;
         end else begin
            hb_dl[0] <= lane_in[l];
            for (int k = 1; k < HB_TAPS-1; k++) begin
               hb_dl[k] <= hb_dl[k-1];
            end
            // Conjugate for even Nyquist zone sampling
            if (hb_fire) begin
               hb_out[l] <= (IS_Q && reverse) ? dhfc_neg(hb_y) : hb_y;
            end
         end
      end

      // FIR steps only on half-band outputs, so it never decimates
      always_ff @(posedge CLOCK) begin
         if (RST) begin
            for (int k = 0; k < FIR_TAPS-1; k++) begin
               fir_dl[k] <= '0;
            end
            fir_out[l] <= '0;
         end else if (hb_v_r) begin
            fir_dl[0] <= hb_out[l];
            for (int k = 1; k < FIR_TAPS-1; k++) begin
               fir_dl[k] <= fir_dl[k-1];
            end
            fir_out[l] <= dhfc_sat(fir_acc >>> FIR_SHIFT);
         end
      end
   end

   // ************************************************************
   // Final shifter and interleaver
   // ************************************************************
   logic [SHIFT_PH_W-1:0] rot_ph_r;
   logic [SHIFT_PH_W-1:0] rot_ph_nxt;
   logic q_pend_r;
   logic q_pend_nxt;
   logic signed [DATA_W-1:0] q_hold0_r;
   logic signed [DATA_W-1:0] q_hold1_r;
   logic push_r;
   logic push_nxt;
   dhfc_word_t push_word_r;
   dhfc_word_t word_nxt;

   wire st_v = fir_en ? fir_v_r : hb_v_r;

   // Quarter turn per output sample is rate/8 at the input clock
   function automatic logic signed [DATA_W-1:0] rotate(
      input logic signed [DATA_W-1:0] i,
      input logic signed [DATA_W-1:0] q,
      input logic [SHIFT_PH_W-1:0] ph);
      logic signed [DATA_W-1:0] r;
      case (ph)
         2'h0: r = i;
         2'h1: r = dhfc_neg(q);
         2'h2: r = dhfc_neg(i);
         default: r = q;
      endcase
      return r;
   endfunction : rotate

   always_comb begin
      word_nxt = push_word_r;
      push_nxt = 1'b0;
      q_pend_nxt = 1'b0;
      rot_ph_nxt = rot_ph_r;
      if (st_v && shift_en) begin
         push_nxt = 1'b1;
         word_nxt.q_tag = 1'b0;
         word_nxt.ch0 = rotate(st[0], st[1], rot_ph_r);
         word_nxt.ch1 = rotate(st[2], st[3], rot_ph_r);
         rot_ph_nxt = rot_ph_r + 1'b1;
      end else if (st_v) begin
         push_nxt = 1'b1;
         word_nxt.q_tag = 1'b0;
         word_nxt.ch0 = st[0];
         word_nxt.ch1 = st[2];
         q_pend_nxt = 1'b1;
      end else if (q_pend_r) begin
         push_nxt = 1'b1;
         word_nxt.q_tag = 1'b1;
         word_nxt.ch0 = q_hold0_r;
         word_nxt.ch1 = q_hold1_r;
      end
      if (sync_accept) rot_ph_nxt = '0;
   end

   // Overflow: stream cannot stall, so a full FIFO drops and flags
   wire ovf_set = push_r && !fifo_in_ready;
   wire ovf_clr = wr_fir && REG_WDATA[BIT_OVF];
   assign ovf_nxt = ovf_set || (ovf_r && !ovf_clr);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rot_ph_r <= '0;
         q_pend_r <= 1'b0;
         q_hold0_r <= '0;
         q_hold1_r <= '0;
         push_r <= 1'b0;
         push_word_r <= '0;
         ovf_r <= 1'b0;
      end else begin
         rot_ph_r <= rot_ph_nxt;
         q_pend_r <= q_pend_nxt;
         if (st_v) q_hold0_r <= st[1];
         if (st_v) q_hold1_r <= st[3];
         push_r <= push_nxt;
         push_word_r <= word_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   assign OVERFLOW = ovf_r;

   dhfc_fifo #(
      .W(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLOCK),
      .rst(RST),
      .in_valid(push_r),
      .in_data(push_word_r),
      .in_ready(fifo_in_ready),
      .out_valid(OUT_VALID),
      .out_data(OUT_WORD),
      .out_ready(OUT_READY)
   );

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_iq_pair;
      push_r && !push_word_r.q_tag ##1 push_r && push_word_r.q_tag;
   endsequence

   sequence s_real_one;
      push_r && !push_word_r.q_tag ##1 !push_r;
   endsequence

   property p_decim;
      @(posedge CLOCK) disable iff (RST)
      !sync_accept |=> (hb_fire != $past(hb_fire));
   endproperty
   a_decim: assert property (p_decim) else $error("bad decimation");

   property p_phase;
      @(posedge CLOCK) disable iff (RST)
      sync_accept |=> (hb_fire == !$past(dec_phase)) ##1
         (hb_fire == $past(dec_phase, 2));
   endproperty
   a_phase: assert property (p_phase) else $error("bad phase");

   property p_once;
      @(posedge CLOCK) disable iff (RST)
      (sync_accept && sync_once && !wr_sync) |=> !armed_r;
   endproperty
   a_once: assert property (p_once) else $error("sync stays armed");

   property p_sync_en;
      @(posedge CLOCK) disable iff (RST)
      (sync_edge && !sync_en && !wr_sync) |=>
         $stable(armed_r) && (dec_cnt_r != $past(dec_cnt_r));
   endproperty
   a_sync_en: assert property (p_sync_en) else $error("sync taken");

   property p_fir_rate;
      @(posedge CLOCK) disable iff (RST)
      (hb_v_r && !hb_fire) |=> fir_v_r ##1 !fir_v_r;
   endproperty
   a_fir_rate: assert property (p_fir_rate) else $error("fir rate");

   property p_bypass;
      @(posedge CLOCK) disable iff (RST)
      (!fir_en && !shift_en && hb_v_r) |=>
         push_r && (push_word_r.ch0 == $past(hb_out[0]));
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass path");

   property p_iq;
      @(posedge CLOCK) disable iff (RST)
      (st_v && !shift_en ##1 !st_v) |-> s_iq_pair;
   endproperty
   a_iq: assert property (p_iq) else $error("iq not interleaved");

   property p_real;
      @(posedge CLOCK) disable iff (RST)
      (st_v && shift_en ##1 !st_v) |-> s_real_one;
   endproperty
   a_real: assert property (p_real) else $error("real word wrong");

   property p_rot;
      @(posedge CLOCK) disable iff (RST)
      (st_v && shift_en && rot_ph_r == 2'h2) |=>
         push_word_r.ch0 == dhfc_neg($past(st[0]));
   endproperty
   a_rot: assert property (p_rot) else $error("shift phase wrong");

   property p_ovf;
      @(posedge CLOCK) disable iff (RST)
      ovf_set |=> OVERFLOW ##1 (OVERFLOW || $past(ovf_clr));
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow lost");

endmodule : dhfc_chain

// ---- test/dhfc_sink.sv ----
// Downstream formatter model for the filter chain output stream
`timescale 1ns/10ps
module dhfc_sink
   import dhfc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Stream from the chain
   input wire dhfc_word_t word,
   input wire logic valid,
   output logic ready,
   // Bench control and status
   input wire logic stall,
   output int count,
   output int hold_err
);
   logic wait_r;
   dhfc_word_t word_r;

   // Stall is a plain level so the bench can back-pressure at will
   assign ready = !stall;

   always_ff @(posedge clk) begin
      if (rst) begin
         wait_r <= 1'b0;
         count <= 0;
         hold_err <= 0;
      end else begin
         // A refused word must stay on offer unchanged
         if (wait_r && (valid !== 1'b1 || word !== word_r)) begin
            hold_err <= hold_err + 1;
         end
         if (valid === 1'b1 && ready) begin
            count <= count + 1;
         end
         wait_r <= (valid === 1'b1) && !ready;
         word_r <= word;
      end
   end
endmodule : dhfc_sink

// ---- test/dhfc_chain_test.sv ----
// Self-checking bench of the filter chain
`timescale 1ns/10ps
module dhfc_chain_test;
   import dhfc_pkg::*;

   // ************************************************************
   // Signals
   // ************************************************************
   localparam int I0 = 1000, Q0 = 3000, I1 = -2000, Q1 = 500;
   logic clock = 1'b0;
   logic rst = 1'b1;
   dhfc_iq_t in0 = '0;
   dhfc_iq_t in1 = '0;
   logic sync_in = 1'b0, reg_we = 1'b0, reg_re = 1'b0, stall = 1'b0;
   logic [REG_ADDR_W-1:0] reg_addr = '0;
   logic [REG_DATA_W-1:0] reg_wdata = '0;
   logic [REG_DATA_W-1:0] reg_rdata;
   logic reg_rvalid, out_valid, out_ready, overflow;
   dhfc_word_t out_word;
   int count, hold_err;
   int bad_count = 0;
   int comparisons = 0;
   longint hb_lp, hb_hp, fir_g;

   always #20 clock = ~clock;

   dhfc_chain #(.FIFO_DEPTH(FIFO_DEPTH_DEF)) DUT (
      .CLOCK(clock), .RST(rst), .IN_CH0(in0), .IN_CH1(in1),
      .SYNC_IN(sync_in), .REG_WE(reg_we), .REG_RE(reg_re),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .REG_RVALID(reg_rvalid), .OUT_WORD(out_word), .OUT_VALID(out_valid),
      .OUT_READY(out_ready), .OVERFLOW(overflow));

   dhfc_sink model (
      .clk(clock), .rst(rst), .word(out_word), .valid(out_valid),
      .ready(out_ready), .stall(stall), .count(count), .hold_err(hold_err));

   // ************************************************************
   // Expectations and compares
   // ************************************************************
   function automatic int hb(input int d, input bit hp);
      return int'((longint'(d) * (hp ? hb_hp : hb_lp)) >>> HB_SHIFT);
   endfunction : hb

   function automatic int fir(input int d);
      return int'((longint'(d) * fir_g) >>> FIR_SHIFT);
   endfunction : fir

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t register %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk16(input logic [DATA_W-1:0] got, input int exp);
      comparisons++;
      if (got !== DATA_W'(exp)) begin
         bad_count++;
         $display("MISMATCH %0t sample %h expected %0d", $time, got, exp);
      end
   endtask : chk16

   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk1

   task automatic chk_n(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         bad_count++;
         $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_n

   // ************************************************************
   // Bus and stream helpers
   // ************************************************************
   task automatic tick;
      @(posedge clock);
      #1;
   endtask : tick

   task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
      reg_we = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick;
      reg_we = 1'b0;
      tick;
   endtask : reg_wr

   task automatic reg_rd(input logic [8:0] a, input logic [7:0] exp);
      reg_re = 1'b1;
      reg_addr = a;
      tick;
      reg_re = 1'b0;
      chk1(reg_rvalid, 1'b1);
      chk8(reg_rdata, exp);
      tick;
   endtask : reg_rd

   // New settings need the FIR delay line flushed before judging
   task automatic cfg(input logic [7:0] fir_v, input logic [7:0] hb_v);
      reg_wr(ADDR_FIR_CTRL, fir_v);
      reg_wr(ADDR_HB_CTRL, hb_v);
      repeat (300) tick;
   endtask : cfg

   task automatic pulse_sync;
      sync_in = 1'b1;
      repeat (3) tick;
      sync_in = 1'b0;
      repeat (6) tick;
   endtask : pulse_sync

   task automatic next_word(output dhfc_word_t w);
      for (int k = 0; k < 64; k++) begin
         if (out_valid === 1'b1 && out_ready === 1'b1) begin
            w = out_word;
            tick;
            return;
         end
         tick;
      end
      bad_count++;
      $display("MISMATCH %0t no output word", $time);
      wrap_up;
   endtask : next_word

   task automatic check_iq(input int ei0, eq0, ei1, eq1);
      dhfc_word_t w;
      next_word(w);
      if (w.q_tag === 1'b1) next_word(w);
      chk1(w.q_tag, 1'b0);
      chk16(w.ch0, ei0);
      chk16(w.ch1, ei1);
      next_word(w);
      chk1(w.q_tag, 1'b1);
      chk16(w.ch0, eq0);
      chk16(w.ch1, eq1);
   endtask : check_iq

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_regs;
      chk1(out_valid, 1'b0);
      reg_rd(ADDR_SYNC_CTRL, 8'h00);
      reg_rd(ADDR_FIR_CTRL, 8'h00);
      reg_rd(ADDR_HB_CTRL, 8'h00);
      reg_rd(9'h101, 8'h00);
      reg_wr(ADDR_HB_CTRL, 8'h0E);
      reg_rd(ADDR_HB_CTRL, 8'h0E);
      reg_wr(9'h101, 8'hFF);
      reg_rd(9'h101, 8'h00);
   endtask : t_regs

   task automatic t_filters;
      cfg(8'h00, 8'h00);
      check_iq(hb(I0, 0), hb(Q0, 0), hb(I1, 0), hb(Q1, 0));
      cfg(8'h00, 8'h02);
      check_iq(hb(I0, 1), hb(Q0, 1), hb(I1, 1), hb(Q1, 1));
      cfg(8'h00, 8'h04);
      check_iq(hb(I0, 0), -hb(Q0, 0), hb(I1, 0), -hb(Q1, 0));
   endtask : t_filters

   task automatic t_fir;
      int c;
      cfg(8'h01, 8'h00);
      check_iq(fir(hb(I0, 0)), fir(hb(Q0, 0)),
         fir(hb(I1, 0)), fir(hb(Q1, 0)));
      c = count;
      repeat (200) tick;
      chk_n(count - c, 200);
   endtask : t_fir

   task automatic t_real;
      int p[4];
      int k, c;
      dhfc_word_t w;
      cfg(8'h03, 8'h00);
      c = count;
      repeat (200) tick;
      chk_n(count - c, 100);
      p = '{fir(hb(I0, 0)), -fir(hb(Q0, 0)), -fir(hb(I0, 0)),
         fir(hb(Q0, 0))};
      k = -1;
      next_word(w);
      for (int j = 0; j < 4; j++) begin
         if (w.ch0 === DATA_W'(p[j])) k = j;
      end
      chk_n(int'(k >= 0), 1);
      for (int n = 1; n < 4; n++) begin
         next_word(w);
         chk1(w.q_tag, 1'b0);
         chk16(w.ch0, p[(k + n + 4) % 4]);
      end
   endtask : t_real

   task automatic t_overflow;
      stall = 1'b1;
      repeat (100) tick;
      chk1(overflow, 1'b1);
      chk1(out_valid, 1'b1);
      reg_rd(ADDR_FIR_CTRL, 8'h83);
      stall = 1'b0;
      repeat (200) tick;
      reg_wr(ADDR_FIR_CTRL, 8'h83);
      reg_rd(ADDR_FIR_CTRL, 8'h03);
      chk1(overflow, 1'b0);
      chk_n(hold_err, 0);
   endtask : t_overflow

   task automatic t_sync_arm;
      reg_wr(ADDR_SYNC_CTRL, 8'h60);
      reg_rd(ADDR_SYNC_CTRL, 8'hE0);
      pulse_sync;
      reg_rd(ADDR_SYNC_CTRL, 8'h60);
      pulse_sync;
      reg_rd(ADDR_SYNC_CTRL, 8'h60);
      reg_wr(ADDR_SYNC_CTRL, 8'h20);
      reg_rd(ADDR_SYNC_CTRL, 8'hA0);
      pulse_sync;
      reg_rd(ADDR_SYNC_CTRL, 8'h20);
      reg_wr(ADDR_SYNC_CTRL, 8'h00);
      pulse_sync;
      reg_rd(ADDR_SYNC_CTRL, 8'h80);
   endtask : t_sync_arm

   // Real mode gives one word per two clocks, so its parity shows phase
   task automatic t_phase;
      int par[2];
      int first;
      reg_wr(ADDR_SYNC_CTRL, 8'h20);
      for (int ph = 0; ph < 2; ph++) begin
         reg_wr(ADDR_HB_CTRL, ph ? 8'h08 : 8'h00);
         repeat (20) tick;
         first = -1;
         sync_in = 1'b1;
         for (int n = 0; n < 40; n++) begin
            if (n == 3) sync_in = 1'b0;
            tick;
            if (n >= 20 && out_valid === 1'b1 && first < 0) first = n;
         end
         par[ph] = first % 2;
      end
      chk_n(par[1], 1 - par[0]);
   endtask : t_phase

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      hb_lp = HB_CENTRE_COEF;
      hb_hp = HB_CENTRE_COEF;
      fir_g = 0;
      for (int k = 0; k < HB_PAIRS; k++) begin
         hb_lp += 2 * HB_COEF[k];
         hb_hp -= 2 * HB_COEF[k];
      end
      for (int k = 0; k < FIR_PAIRS; k++) fir_g += 2 * FIR_COEF[k];
      in0 = {DATA_W'(I0), DATA_W'(Q0)};
      in1 = {DATA_W'(I1), DATA_W'(Q1)};
      repeat (5) tick;
      rst = 1'b0;
      t_regs;
      t_filters;
      t_fir;
      t_real;
      t_overflow;
      t_sync_arm;
      t_phase;
      wrap_up;
   end
endmodule : dhfc_chain_test
